//--- shared/mcs_pkg.sv
/*
 * shared constants, register map, carriers and state codes for the
 * collision / carrier-sense status block.
 * assumes a 10 MHz system clock and a 5-bit by 16-bit register space
 * that is shared by the local register port and the serial management line.
 */
`default_nettype none
package mcs_pkg;
	// ****************************************
	// register space
	// ****************************************
	localparam int unsigned REG_AW = 5;
	localparam int unsigned REG_DW = 16;
	localparam logic [4:0] ADDR_MODE = 5'h10;
	localparam logic [4:0] ADDR_TEST = 5'h12;
	localparam logic [4:0] ADDR_STAT = 5'h13;
	localparam logic [4:0] ADDR_IRQ = 5'h14;
	localparam logic [4:0] ADDR_MASK = 5'h15;
	localparam int unsigned BIT_SUPPRESS = 2;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] TEST_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	// ****************************************
	// receive symbols and timing
	// ****************************************
	localparam int unsigned SYM_W = 10;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned SQE_DELAY_NS = 1000;
	localparam int unsigned SQE_WIDTH_NS = 1000;
	// least delay rounds up, longest width rounds down, never below one
	localparam int unsigned SQE_DELAY_CYC = (SQE_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SQE_WIDTH_RAW = SQE_WIDTH_NS / CLK_NS;
	localparam int unsigned SQE_WIDTH_CYC = (SQE_WIDTH_RAW < 1) ? 1 : SQE_WIDTH_RAW;
	localparam int unsigned SQE_CNT_W = 8;
	// ****************************************
	// management frame layout
	// ****************************************
	localparam logic [3:0] MD_HDR_LAST = 4'hb;
	localparam logic [3:0] MD_TA_LAST = 4'h1;
	localparam logic [3:0] MD_DATA_LAST = 4'hf;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] START_HIST = 2'h2;
	// ****************************************
	// carriers and state codes
	// ****************************************
	typedef struct packed {
		logic [12:0] rsvd;
		logic repeater;
		logic full_duplex;
		logic speed_100;
	} mcs_mode_t;
	typedef struct packed {
		logic [12:0] rsvd;
		logic sqe;
		logic carrier;
		logic collision;
	} mcs_evt_t;
	typedef struct packed {
		logic [11:0] rsvd;
		logic rx_active;
		logic speed;
		logic crs;
		logic col;
	} mcs_stat_t;
	typedef enum logic [1:0] {
		MD_IDLE = 2'b00,
		MD_HDR = 2'b01,
		MD_TA = 2'b10,
		MD_DATA = 2'b11
	} mcs_md_state_t;
endpackage
`default_nettype wire

//--- hdl/mcs_status.sv
/*
 * collision, carrier-sense and speed indication for the mac side of a
 * 10/100 transceiver, with a small register file reached both over a local
 * register port and over the serial management line.
 * assumes: clk_sys_in at 10 MHz; tx enable, squelch-free receive, the
 * management clock and data arrive asynchronously; receive symbols come from
 * logic on clk_sys_in.
 */
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mcs_status #(
	parameter logic [4:0] PHY_ADDR = 5'h01 // arbitrary management address
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// mac and line activity
	input wire logic tx_en_in,
	input wire logic rx_squelch_free_in,
	input wire logic [mcs_pkg::SYM_W-1:0] rx_symbol_in,
	input wire logic rx_symbol_valid_in,
	// status to the mac
	output logic col_out,
	output logic crs_out,
	output logic speed_indication_out,
	output logic irq_out,
	// local register port
	input wire logic [mcs_pkg::REG_AW-1:0] reg_addr_in,
	input wire logic [mcs_pkg::REG_DW-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [mcs_pkg::REG_DW-1:0] reg_rdata_out,
	// management line
	input wire logic mdc_in,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_out
);
	// ****************************************
	// helpers
	// ****************************************
	// true when two zero bits sit at least two positions apart
	function automatic logic sym_gap_zeros(
		input logic [mcs_pkg::SYM_W-1:0] sym
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < mcs_pkg::SYM_W; i++) begin
			for (int j = i + 2; j < mcs_pkg::SYM_W; j++) begin
				if (!sym[i] && !sym[j]) begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction

	// ****************************************
	// synchronisers
	// ****************************************
	logic [3:0] meta;
	logic tx_s, sq_s, mdc_s, mdio_s, tx_q, mdc_q;
	// first stage is only read by the second
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta <= 4'h0;
			tx_s <= 1'b0;
			sq_s <= 1'b0;
			mdc_s <= 1'b0;
			mdio_s <= 1'b1;
			tx_q <= 1'b0;
			mdc_q <= 1'b0;
		end else begin
			meta <= {mdio_in, mdc_in, rx_squelch_free_in, tx_en_in};
			tx_s <= meta[0];
			sq_s <= meta[1];
			mdc_s <= meta[2];
			mdio_s <= meta[3];
			tx_q <= tx_s;
			mdc_q <= mdc_s;
		end
	end
	logic mdc_rise, mdc_fall, tx_fall;
	assign mdc_rise = mdc_s && !mdc_q;
	assign mdc_fall = !mdc_s && mdc_q;
	assign tx_fall = !tx_s && tx_q;

	// ****************************************
	// registers
	// ****************************************
	mcs_pkg::mcs_mode_t mode;
	logic [mcs_pkg::REG_DW-1:0] test_ctl, irq_mask;
	mcs_pkg::mcs_evt_t irq_stat, evt;
	mcs_pkg::mcs_stat_t stat;
	logic md_wr;
	logic [4:0] md_addr;
	logic [15:0] md_wdata;
	logic suppress;
	assign suppress = test_ctl[mcs_pkg::BIT_SUPPRESS];

	function automatic logic [15:0] reg_read(input logic [4:0] a,
		input logic [15:0] m, input logic [15:0] t, input logic [15:0] s,
		input logic [15:0] iq, input logic [15:0] mk);
		logic [15:0] d;
		d = mcs_pkg::ZERO_WORD;
		if (a == mcs_pkg::ADDR_MODE) d = m;
		if (a == mcs_pkg::ADDR_TEST) d = t;
		if (a == mcs_pkg::ADDR_STAT) d = s;
		if (a == mcs_pkg::ADDR_IRQ) d = iq;
		if (a == mcs_pkg::ADDR_MASK) d = mk;
		return d;
	endfunction

	// writes from the management line, then the local port, which wins a tie
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode <= mcs_pkg::MODE_RESET;
			test_ctl <= mcs_pkg::TEST_RESET;
			irq_mask <= mcs_pkg::MASK_RESET;
		end else begin
			if (md_wr && md_addr == mcs_pkg::ADDR_MODE) mode <= md_wdata;
			if (md_wr && md_addr == mcs_pkg::ADDR_TEST) test_ctl <= md_wdata;
			if (md_wr && md_addr == mcs_pkg::ADDR_MASK) irq_mask <= md_wdata;
			if (reg_wr_in && reg_addr_in == mcs_pkg::ADDR_MODE) begin
				mode <= reg_wdata_in;
			end
			if (reg_wr_in && reg_addr_in == mcs_pkg::ADDR_TEST) begin
				test_ctl <= reg_wdata_in;
			end
			if (reg_wr_in && reg_addr_in == mcs_pkg::ADDR_MASK) begin
				irq_mask <= reg_wdata_in;
			end
		end
	end

	// sticky events: a new event beats a write-one clear in the same cycle
	logic [15:0] irq_clr;
	always_comb begin
		irq_clr = mcs_pkg::ZERO_WORD;
		if (reg_wr_in && reg_addr_in == mcs_pkg::ADDR_IRQ) irq_clr = reg_wdata_in;
		if (md_wr && md_addr == mcs_pkg::ADDR_IRQ) irq_clr = irq_clr | md_wdata;
	end
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_stat <= mcs_pkg::ZERO_WORD;
			irq_out <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | evt;
			irq_out <= |(irq_stat & irq_mask);
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= mcs_pkg::ZERO_WORD;
		end else if (reg_rd_in) begin
			reg_rdata_out <= reg_read(reg_addr_in, mode, test_ctl, stat,
				irq_stat, irq_mask);
		end else begin
			reg_rdata_out <= mcs_pkg::ZERO_WORD;
		end
	end

	// ****************************************
	// receive activity and quality test
	// ****************************************
	logic rx_act100, rx_act;
	// a symbol's verdict holds until the next symbol arrives
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_act100 <= 1'b0;
		end else if (rx_symbol_valid_in) begin
			rx_act100 <= sym_gap_zeros(rx_symbol_in);
		end
	end
	assign rx_act = mode.speed_100 ? rx_act100 : sq_s;

	// test pulse follows the end of each 10 Mb/s transmission
	logic [mcs_pkg::SQE_CNT_W-1:0] sqe_cnt;
	logic sqe_pulse;
	localparam logic [mcs_pkg::SQE_CNT_W-1:0] SQE_LOAD =
		mcs_pkg::SQE_CNT_W'(mcs_pkg::SQE_DELAY_CYC + mcs_pkg::SQE_WIDTH_CYC);
	localparam logic [mcs_pkg::SQE_CNT_W-1:0] SQE_WIDTH =
		mcs_pkg::SQE_CNT_W'(mcs_pkg::SQE_WIDTH_CYC);
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sqe_cnt <= '0;
		end else if (tx_fall && !mode.speed_100) begin
			sqe_cnt <= SQE_LOAD;
		end else if (sqe_cnt != '0) begin
			sqe_cnt <= sqe_cnt - 1'b1;
		end
	end
	assign sqe_pulse = (sqe_cnt != '0) && (sqe_cnt <= SQE_WIDTH);

	// ****************************************
	// status outputs
	// ****************************************
	logic next_col, next_crs;
	always_comb begin
		next_col = (tx_s && rx_act) || (sqe_pulse && !suppress);
		if (mode.full_duplex) next_col = 1'b0;
		if (mode.full_duplex || mode.repeater) begin
			next_crs = rx_act;
		end else begin
			next_crs = rx_act || tx_s;
		end
	end
	// outputs are glitch free flops but unrelated to the mac's clocks
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			col_out <= 1'b0;
			crs_out <= 1'b0;
		end else begin
			col_out <= next_col;
			crs_out <= next_crs;
		end
	end
	assign speed_indication_out = mode.speed_100;
	always_comb begin
		stat = mcs_pkg::ZERO_WORD;
		stat.col = col_out;
		stat.crs = crs_out;
		stat.speed = mode.speed_100;
		stat.rx_active = rx_act;
		evt = mcs_pkg::ZERO_WORD;
		evt.collision = next_col && !col_out;
		evt.carrier = next_crs && !crs_out;
		evt.sqe = sqe_cnt == SQE_WIDTH;
	end

	// ****************************************
	// management frame engine
	// ****************************************
	mcs_pkg::mcs_md_state_t md_state;
	logic [3:0] md_cnt;
	logic [1:0] md_hist;
	logic [11:0] md_hdr;
	logic [15:0] md_sh;
	logic md_read;
	// sample on clock rise only; preamble ones then 01 opens a frame
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			md_state <= mcs_pkg::MD_IDLE;
			md_cnt <= 4'h0;
			md_hist <= 2'h0;
			md_hdr <= 12'h000;
			md_sh <= mcs_pkg::ZERO_WORD;
			md_wr <= 1'b0;
		end else begin
			md_wr <= 1'b0;
			if (mdc_rise) begin
				md_hist <= {md_hist[0], mdio_s};
				md_cnt <= md_cnt + 1'b1;
				unique case (md_state)
				mcs_pkg::MD_IDLE: begin
					md_cnt <= 4'h0;
					if (md_hist == mcs_pkg::START_HIST && mdio_s) begin
						md_state <= mcs_pkg::MD_HDR;
					end
				end
				mcs_pkg::MD_HDR: begin
					md_hdr <= {md_hdr[10:0], mdio_s};
					if (md_cnt == mcs_pkg::MD_HDR_LAST) begin
						md_state <= mcs_pkg::MD_TA;
						md_cnt <= 4'h0;
					end
				end
				mcs_pkg::MD_TA: begin
					if (md_cnt == mcs_pkg::MD_TA_LAST) begin
						md_state <= mcs_pkg::MD_DATA;
						md_cnt <= 4'h0;
						md_sh <= reg_read(md_hdr[4:0], mode, test_ctl, stat,
							irq_stat, irq_mask);
					end
				end
				mcs_pkg::MD_DATA: begin
					if (!md_read) md_sh <= {md_sh[14:0], mdio_s};
					if (md_cnt == mcs_pkg::MD_DATA_LAST) begin
						md_state <= mcs_pkg::MD_IDLE;
						md_hist <= 2'h0;
						md_wr <= !md_read && md_hdr[11:10] == mcs_pkg::OP_WRITE &&
							md_hdr[9:5] == PHY_ADDR;
					end
				end
				endcase
			end else if (mdc_fall && md_read && md_state == mcs_pkg::MD_DATA) begin
				// the bit driven at this fall leaves; the next one moves up
				md_sh <= {md_sh[14:0], 1'b0};
			end
		end
	end
	assign md_addr = md_hdr[4:0];
	assign md_wdata = md_sh;
	assign md_read = md_hdr[11:10] == mcs_pkg::OP_READ &&
		md_hdr[9:5] == PHY_ADDR;

	// drive only after a clock fall, so the far end samples a settled bit
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mdio_out <= 1'b1;
			mdio_oe_out <= 1'b0;
		end else if (mdc_fall) begin
			mdio_oe_out <= md_read && (md_state == mcs_pkg::MD_DATA ||
				(md_state == mcs_pkg::MD_TA && md_cnt == mcs_pkg::MD_TA_LAST));
			mdio_out <= (md_state == mcs_pkg::MD_DATA) ? md_sh[15] : 1'b0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_speed_follows_write: assert property (
		reg_wr_in && reg_addr_in == mcs_pkg::ADDR_MODE |=>
		speed_indication_out == $past(reg_wdata_in[0]))
		else $error("speed indication did not follow mode write");
	a_col_tx_rx: assert property (
		!mode.full_duplex && tx_s && rx_act |=> col_out)
		else $error("collision missed during transmit");
	a_col_10m_line: assert property (
		!mode.speed_100 && !mode.full_duplex && tx_s && sq_s |=> col_out)
		else $error("10 Mb/s line activity gave no collision");
	a_col_100m_symbol: assert property (
		rx_symbol_valid_in && sym_gap_zeros(rx_symbol_in) ##1
		(tx_s && mode.speed_100 && !mode.full_duplex && !rx_symbol_valid_in)
		|=> col_out)
		else $error("active symbol gave no collision");
	a_col_fd_low: assert property (
		mode.full_duplex |=> !col_out)
		else $error("collision in full duplex");
	a_sqe_blocked: assert property (
		suppress && !(tx_s && rx_act) |=> !col_out)
		else $error("suppressed test pulse reached collision");
	a_sqe_shown: assert property (
		!suppress && !mode.full_duplex && sqe_pulse |=> col_out)
		else $error("test pulse missing on collision");
	a_crs_half: assert property (
		!mode.full_duplex && !mode.repeater && (tx_s || rx_act) |=> crs_out)
		else $error("carrier sense missing in half duplex");
	a_crs_rx_only: assert property (
		(mode.full_duplex || mode.repeater) && !rx_act |=> !crs_out)
		else $error("own transmit raised carrier sense");
	a_mdio_fall_step: assert property (
		$changed(mdio_oe_out) || $changed(mdio_out) |-> $past(mdc_fall))
		else $error("data line moved off the clock fall");
	c_collision: cover property (tx_s && rx_act ##1 col_out);
	c_sqe: cover property (sqe_pulse && !suppress ##1 col_out);
	c_md_read: cover property ($rose(mdio_oe_out));
	c_md_write: cover property (md_wr);
endmodule // mcs_status
`default_nettype wire

//--- verification/mcs_sta_model.sv
/*
 * station management and mac model: makes the management clock only
 * inside frames, shifts frames msb first, synchronises col and crs.
 * assumes a 10 MHz clk_in and a pulled-up data line resolved by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module mcs_sta_model (
	// clock
	input wire logic clk_in,
	// management line
	output logic mdc_out,
	output logic mdio_out,
	output logic mdio_oe_out,
	input wire logic mdio_in,
	// status from the device
	input wire logic col_in,
	input wire logic crs_in,
	output logic col_sync_out,
	output logic crs_sync_out
);
	logic [1:0] col_q;
	logic [1:0] crs_q;
	// two flops each: both lines are asynchronous to the mac clock
	always_ff @(posedge clk_in) begin
		col_q <= {col_q[0], col_in};
		crs_q <= {crs_q[0], crs_in};
	end
	assign col_sync_out = col_q[1];
	assign crs_sync_out = crs_q[1];
	// idle: clock stands low, line released
	initial begin
		mdc_out = 1'b0;
		mdio_out = 1'b1;
		mdio_oe_out = 1'b0;
	end
	// ****************************************
	// frame shifting
	// ****************************************
	// one bit: data moves while the clock is low, sampled at the rise
	task automatic bit_cyc(input logic drv, input logic val, output logic seen);
		@(posedge clk_in);
		mdc_out <= 1'b0;
		mdio_oe_out <= drv;
		mdio_out <= drv ? val : 1'b1;
		repeat (4) @(posedge clk_in);
		seen = mdio_in;
		mdc_out <= 1'b1;
		repeat (3) @(posedge clk_in);
	endtask
	// whole frame; got holds the second turnaround bit and the data
	task automatic frame(input logic rd, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd, output logic [16:0] got);
		logic [45:0] hdr;
		logic [17:0] tw;
		logic s;
		hdr = {32'hffffffff, 2'b01, (rd ? 2'b10 : 2'b01), phy, ra};
		tw = {2'b10, wd};
		got = '0;
		for (int i = 45; i >= 0; i--) begin
			bit_cyc(1'b1, hdr[i], s);
		end
		for (int i = 17; i >= 0; i--) begin
			bit_cyc(!rd, tw[i], s);
			if (i < 17) begin
				got[i] = s;
			end
		end
		@(posedge clk_in);
		mdc_out <= 1'b0;
		mdio_oe_out <= 1'b0;
		mdio_out <= 1'b1;
	endtask
endmodule // mcs_sta_model
`default_nettype wire

//--- verification/tb_mcs_status.sv
/*
 * self-checking bench for the collision / carrier-sense block.
 * assumes mcs_pkg and the station model; the data line has a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_mcs_status;
	localparam logic [4:0] PHY = 5'h01; // arbitrary address
	logic clk, rst_n, tx_en, sq, sym_v, wr, rd;
	logic [mcs_pkg::SYM_W-1:0] sym;
	logic col, crs, spd, irq, col_s, crs_s;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, rv;
	logic mdc, sta_do, sta_oe, dev_do, dev_oe, line;
	logic [16:0] got;
	logic [5:0] tbl [7];
	logic [10:0] stb [4];
	logic [17:0] sqt [3];
	int err_total, n_tests, n;
	// released line reads high through the pull-up
	assign line = dev_oe ? dev_do : (sta_oe ? sta_do : 1'b1);
	mcs_status #(.PHY_ADDR(PHY)) dut (.clk_sys_in(clk), .rst_n_in(rst_n),
		.tx_en_in(tx_en), .rx_squelch_free_in(sq), .rx_symbol_in(sym),
		.rx_symbol_valid_in(sym_v), .col_out(col), .crs_out(crs),
		.speed_indication_out(spd), .irq_out(irq), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .mdc_in(mdc), .mdio_in(line),
		.mdio_out(dev_do), .mdio_oe_out(dev_oe));
	mcs_sta_model sta (.clk_in(clk), .mdc_out(mdc), .mdio_out(sta_do),
		.mdio_oe_out(sta_oe), .mdio_in(line), .col_in(col), .crs_in(crs),
		.col_sync_out(col_s), .crs_sync_out(crs_s));
	// 100 ns clock stands in for the reference clock of the system
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// transmit burst then count collision cycles after its end
	task automatic sqe_run(output int cnt);
		@(posedge clk);
		tx_en <= 1'b1;
		repeat (5) @(posedge clk);
		tx_en <= 1'b0;
		cnt = 0;
		repeat (40) begin
			@(negedge clk);
			if (col === 1'b1) cnt++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// watchdog: the tests need about 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rst_n, tx_en, sq, sym_v, wr, rd} = '0;
		sym = '1;
		addr = '0;
		wdata = '0;
		err_total = 0;
		n_tests = 0;
		// mode 01 full, 10 repeater; tx, rx; expected col, crs
		tbl = '{6'b001111, 6'b001001, 6'b000101, 6'b011101, 6'b011000,
			6'b101000, 6'b101111};
		stb = '{{10'h3f6, 1'b1}, {10'h3fc, 1'b0}, {10'h3ff, 1'b0},
			{10'h1fe, 1'b1}};
		sqt = '{{16'h0000, 2'd0}, {16'h0004, 2'd0}, {16'h0000, 2'd1}};
		repeat (12) @(posedge clk);
		check("oe in reset", {15'h0, dev_oe}, 16'h0000);
		rst_n <= 1'b1;
		reg_rd(mcs_pkg::ADDR_MODE, rv);
		check("mode reset", rv, mcs_pkg::MODE_RESET);
		reg_rd(mcs_pkg::ADDR_TEST, rv);
		check("test reset", rv, mcs_pkg::TEST_RESET);
		reg_rd(mcs_pkg::ADDR_MASK, rv);
		check("mask reset", rv, mcs_pkg::MASK_RESET);
		check("speed 10", {15'h0, spd}, 16'h0000);
		reg_wr(5'h1f, 16'hffff);
		reg_rd(5'h1f, rv);
		check("unmapped", rv, mcs_pkg::ZERO_WORD);
		reg_wr(mcs_pkg::ADDR_STAT, 16'hffff);
		reg_rd(mcs_pkg::ADDR_STAT, rv);
		check("status ro", rv, mcs_pkg::ZERO_WORD);
		// suppress the test pulse so tx ends do not disturb the table
		reg_wr(mcs_pkg::ADDR_TEST, 16'h0004);
		for (int i = 0; i < 7; i++) begin
			reg_wr(mcs_pkg::ADDR_MODE, {12'h0, tbl[i][5:4], 2'b00} >> 1);
			tx_en <= tbl[i][3];
			sq <= tbl[i][2];
			repeat (8) @(posedge clk);
			check("col", {15'h0, col_s}, {15'h0, tbl[i][1]});
			check("crs", {15'h0, crs_s}, {15'h0, tbl[i][0]});
			tx_en <= 1'b0;
			sq <= 1'b0;
			repeat (8) @(posedge clk);
		end
		// 100 Mb/s symbols while transmitting
		reg_wr(mcs_pkg::ADDR_MODE, 16'h0001);
		tx_en <= 1'b1;
		repeat (4) @(posedge clk);
		check("speed 100", {15'h0, spd}, 16'h0001);
		reg_rd(mcs_pkg::ADDR_STAT, rv);
		check("stat live", rv, 16'h0006);
		for (int i = 0; i < 4; i++) begin
			sym <= stb[i][10:1];
			sym_v <= 1'b1;
			@(posedge clk);
			sym_v <= 1'b0;
			repeat (6) @(posedge clk);
			check("sym col", {15'h0, col_s}, {15'h0, stb[i][0]});
		end
		tx_en <= 1'b0;
		// test pulse: plain, suppressed, full duplex
		for (int i = 0; i < 3; i++) begin
			reg_wr(mcs_pkg::ADDR_TEST, sqt[i][17:2]);
			reg_wr(mcs_pkg::ADDR_MODE, {14'h0, sqt[i][1:0]} << 1);
			sqe_run(n);
			check("sqe", 16'(n), i == 0 ? 16'(mcs_pkg::SQE_WIDTH_CYC) : '0);
		end
		check("irq masked", {15'h0, irq}, 16'h0000);
		reg_rd(mcs_pkg::ADDR_IRQ, rv);
		check("irq test", rv & 16'h0004, 16'h0004);
		reg_wr(mcs_pkg::ADDR_MASK, 16'h0004);
		repeat (2) @(posedge clk);
		check("irq on", {15'h0, irq}, 16'h0001);
		reg_wr(mcs_pkg::ADDR_IRQ, 16'h0007);
		repeat (2) @(posedge clk);
		check("irq off", {15'h0, irq}, 16'h0000);
		reg_rd(mcs_pkg::ADDR_IRQ, rv);
		check("irq clear", rv, mcs_pkg::ZERO_WORD);
		// management frames: write, read back, foreign address
		sta.frame(1'b0, PHY, mcs_pkg::ADDR_MODE, 16'h0001, got);
		repeat (8) @(posedge clk);
		check("md write", {15'h0, spd}, 16'h0001);
		reg_wr(mcs_pkg::ADDR_TEST, 16'h0004);
		sta.frame(1'b1, PHY, mcs_pkg::ADDR_TEST, 16'h0000, got);
		check("md ta", {15'h0, got[16]}, 16'h0000);
		check("md read", got[15:0], 16'h0004);
		sta.frame(1'b0, PHY + 5'h01, mcs_pkg::ADDR_MODE, 16'h0000, got);
		repeat (8) @(posedge clk);
		check("md other", {15'h0, spd}, 16'h0001);
		report_and_stop();
	end
endmodule // tb_mcs_status
`default_nettype wire
